// File: fsps_params.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH

// Register byte offsets on the bus
`define FSPS_OFF_CTRL      8'h00
`define FSPS_OFF_STAT      8'h04

// Control register command patterns in the low five bits
`define FSPS_CODE_LOAD     5'b00001
`define FSPS_CODE_ERASE    5'b00011
`define FSPS_CODE_WRITE    5'b00101
`define FSPS_CODE_FLUSH    5'b10001

// Control register read-back bit positions
`define FSPS_CTRL_EN_BIT   0
`define FSPS_CTRL_ERS_BIT  1
`define FSPS_CTRL_WRT_BIT  2

// Status register bit positions
`define FSPS_STAT_HALT_BIT 0
`define FSPS_STAT_EE_BIT   1
`define FSPS_STAT_BUF_BIT  2
`define FSPS_STAT_ST_LSB   3

// Reset and clear values
`define FSPS_RDATA_RST     32'h0000_0000
`define FSPS_ERASED_WORD   16'hffff

// Store window length in clock cycles
`define FSPS_ARM_CYCLES    3'd4

`endif

// File: fsps_pkg.sv
// Types shared by the flash self-program sequencer
package fsps_pkg;

  // Armed command held in the control register
  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_LOAD  = 2'h1,
    CMD_ERASE = 2'h2,
    CMD_WRITE = 2'h3
  } fsps_cmd_t;

  // Sequencer states, Gray along idle-stream-wait and idle-erase
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STREAM = 2'b01,
    ST_WAIT   = 2'b11,
    ST_ERASE  = 2'b10
  } fsps_state_t;

endpackage

// File: fsps_arm_window.sv
// Four-cycle arming window for the store instruction
`timescale 1ns/1ps
`include "fsps_params.svh"
module fsps_arm_window
  import fsps_pkg::*;
(
  // Clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // Arming from a control write
  input  wire logic      arm_load,
  input  wire fsps_cmd_t arm_cmd,
  // Store instruction and flash completion
  input  wire logic      fire,
  input  wire logic      op_done,
  // Armed command and acceptance
  output fsps_cmd_t      cmd,
  output logic           accept
);

  typedef struct packed {
    fsps_cmd_t  cmd;
    logic [2:0] cnt;
    logic       busy;
  } fsps_arm_t;

  fsps_arm_t s_q;
  fsps_arm_t s_d;

  assign cmd    = s_q.cmd;
  assign accept = fire && (s_q.cmd != CMD_NONE) && !s_q.busy;

  // Window countdown, hold during erase or write
  always_comb begin
    s_d = s_q;
    if (s_q.busy) begin
      if (op_done) begin
        s_d.busy = 1'b0;
        s_d.cmd  = CMD_NONE;
      end
    end else if (accept) begin
      s_d.cnt = 3'd0;
      if (s_q.cmd == CMD_LOAD) begin
        s_d.cmd = CMD_NONE;
      end else begin
        s_d.busy = 1'b1;
      end
    end else if (arm_load) begin
      s_d.cmd = arm_cmd;
      s_d.cnt = `FSPS_ARM_CYCLES;
    end else if (s_q.cmd != CMD_NONE) begin
      s_d.cnt = s_q.cnt - 3'd1;
      if (s_q.cnt == 3'd1) begin
        s_d.cmd = CMD_NONE;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{cmd: CMD_NONE, cnt: 3'd0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  property p_window_expire;
    @(posedge hclk) disable iff (!hresetn)
      arm_load ##1 (!fire && !arm_load)[*4] |=> (cmd == CMD_NONE);
  endproperty
  a_window_expire: assert property (p_window_expire)
    else $error("armed command outlived its window");

  property p_busy_holds;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.busy && !op_done) |=> (cmd != CMD_NONE) && s_q.busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("store enable dropped during an operation");

endmodule

// File: fsps_page_buf.sv
// Temporary page buffer with once-only word loading
`timescale 1ns/1ps
`include "fsps_params.svh"
module fsps_page_buf #(
  parameter int WORD_BITS = 5
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Load and clear
  input  wire logic                 clr,
  input  wire logic                 we,
  input  wire logic [WORD_BITS-1:0] widx,
  input  wire logic [15:0]          wdata,
  // Read port
  input  wire logic [WORD_BITS-1:0] ridx,
  output logic [15:0]               rdata,
  output logic                      any_loaded
);

  localparam int WORDS = 1 << WORD_BITS;

  typedef struct packed {
    logic [WORDS-1:0][15:0] words;
    logic [WORDS-1:0]       loaded;
  } fsps_buf_t;

  fsps_buf_t s_q;
  fsps_buf_t s_d;

  assign rdata      = s_q.words[ridx];
  assign any_loaded = |s_q.loaded;

  // Clear wins; a location takes only its first load
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.words  = {WORDS{`FSPS_ERASED_WORD}};
      s_d.loaded = '0;
    end else if (we && !s_q.loaded[widx]) begin
      s_d.words[widx]  = wdata;
      s_d.loaded[widx] = 1'b1;
    end
  end

  // Buffer storage, cleared by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{words: {WORDS{`FSPS_ERASED_WORD}}, loaded: '0};
    end else begin
      s_q <= s_d;
    end
  end

  property p_single_load;
    @(posedge hclk) disable iff (!hresetn)
      (we && s_q.loaded[widx] && !clr) |=> $stable(s_q.words);
  endproperty
  a_single_load: assert property (p_single_load)
    else $error("loaded location was overwritten");

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
      clr |=> (s_q.loaded == '0) && (rdata == `FSPS_ERASED_WORD);
  endproperty
  a_clear: assert property (p_clear)
    else $error("buffer not cleared");

endmodule

// File: fsps_top.sv
// Flash self-program sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`include "fsps_params.svh"
module fsps_top
  import fsps_pkg::*;
#(
  parameter int PAGE_BITS = 6,
  parameter int WORD_BITS = 5
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Store instruction from the CPU core
  input  wire logic                 program_store_instruction,
  input  wire logic [15:0]          store_ptr,
  input  wire logic [7:0]           data_high_reg,
  input  wire logic [7:0]           data_low_reg,
  // EEPROM activity
  input  wire logic                 eeprom_write_busy,
  // CPU control
  output logic                      cpu_halt,
  // Flash array
  input  wire logic                 flash_done,
  output logic                      flash_erase,
  output logic                      flash_prog,
  output logic [PAGE_BITS-1:0]      flash_page,
  output logic [WORD_BITS-1:0]      flash_word,
  output logic [15:0]               flash_wdata
);

  typedef struct packed {
    fsps_state_t          st;
    logic                 wr_pend;
    logic [7:0]           addr;
    logic                 mapped;
    logic [31:0]          hrdata;
    logic                 hready;
    logic                 hresp;
    logic                 halt;
    logic                 erase;
    logic                 prog;
    logic [PAGE_BITS-1:0] page;
    logic [WORD_BITS-1:0] word;
    logic [WORD_BITS-1:0] idx;
    logic [15:0]          wdata;
  } fsps_top_t;

  fsps_top_t s_q;
  fsps_top_t s_d;

  // Page part of the pointer, above the word field and byte bit
  function automatic logic [PAGE_BITS-1:0] page_index_field(
    input logic [15:0] ptr
  );
    page_index_field = ptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  endfunction

  // Word part of the pointer, byte bit dropped
  function automatic logic [WORD_BITS-1:0] word_in_page_field(
    input logic [15:0] ptr
  );
    word_in_page_field = ptr[WORD_BITS:1];
  endfunction

  // Command decode of the low five control bits
  function automatic fsps_cmd_t decode_cmd(input logic [4:0] code);
    unique case (code)
      `FSPS_CODE_LOAD:  decode_cmd = CMD_LOAD;
      `FSPS_CODE_ERASE: decode_cmd = CMD_ERASE;
      `FSPS_CODE_WRITE: decode_cmd = CMD_WRITE;
      default:          decode_cmd = CMD_NONE;
    endcase
  endfunction

  // Internal nets
  fsps_cmd_t            arm_cmd;
  fsps_cmd_t            cur_cmd;
  logic                 arm_load;
  logic                 flush_hit;
  logic                 accept;
  logic                 op_done;
  logic                 buf_clr;
  logic                 buf_we;
  logic [15:0]          buf_rdata;
  logic                 buf_any;
  logic                 ctrl_wr;
  logic                 addr_ph;
  logic [31:0]          rd_mux;

  // Bus address phase and control write decode
  assign addr_ph   = hsel && htrans[1] && hready;
  assign ctrl_wr   = s_q.wr_pend && s_q.mapped &&
                     (s_q.addr == `FSPS_OFF_CTRL);
  assign arm_cmd   = decode_cmd(hwdata[4:0]);
  // Writes while EEPROM busy or an operation runs are dropped
  assign arm_load  = ctrl_wr && !eeprom_write_busy && !s_q.halt &&
                     (arm_cmd != CMD_NONE);
  assign flush_hit = ctrl_wr && !eeprom_write_busy && !s_q.halt &&
                     (hwdata[4:0] == `FSPS_CODE_FLUSH);

  // Completion of the running flash operation
  assign op_done = flash_done &&
                   ((s_q.st == ST_ERASE) || (s_q.st == ST_WAIT));

  // Buffer load and clear sources
  assign buf_we  = accept && (cur_cmd == CMD_LOAD);
  assign buf_clr = flush_hit || eeprom_write_busy ||
                   (flash_done && (s_q.st == ST_WAIT));

  // Register read mux
  always_comb begin
    rd_mux = `FSPS_RDATA_RST;
    if (haddr[31:8] == 24'h000000) begin
      if (haddr[7:0] == `FSPS_OFF_CTRL) begin
        rd_mux[`FSPS_CTRL_EN_BIT]  = (cur_cmd != CMD_NONE);
        rd_mux[`FSPS_CTRL_ERS_BIT] = (cur_cmd == CMD_ERASE);
        rd_mux[`FSPS_CTRL_WRT_BIT] = (cur_cmd == CMD_WRITE);
      end else if (haddr[7:0] == `FSPS_OFF_STAT) begin
        rd_mux[`FSPS_STAT_HALT_BIT] = s_q.halt;
        rd_mux[`FSPS_STAT_EE_BIT]   = eeprom_write_busy;
        rd_mux[`FSPS_STAT_BUF_BIT]  = buf_any;
        rd_mux[`FSPS_STAT_ST_LSB+:2] = s_q.st;
      end
    end
  end

  // Bus slave and sequencer next state
  always_comb begin
    s_d = s_q;
    s_d.hready  = 1'b1;
    s_d.hresp   = 1'b0;
    s_d.hrdata  = `FSPS_RDATA_RST;
    s_d.wr_pend = addr_ph && hwrite;
    s_d.erase   = 1'b0;
    s_d.prog    = 1'b0;
    if (addr_ph) begin
      s_d.addr   = haddr[7:0];
      s_d.mapped = (haddr[31:8] == 24'h000000);
      if (!hwrite) begin
        s_d.hrdata = rd_mux;
      end
    end
    unique case (s_q.st)
      ST_IDLE: begin
        // Any pointer value is taken; there is no loader region check
        if (accept && (cur_cmd == CMD_ERASE)) begin
          s_d.st    = ST_ERASE;
          s_d.halt  = 1'b1;
          s_d.erase = 1'b1;
          s_d.page  = page_index_field(store_ptr);
        end else if (accept && (cur_cmd == CMD_WRITE)) begin
          s_d.st   = ST_STREAM;
          s_d.halt = 1'b1;
          s_d.page = page_index_field(store_ptr);
          s_d.idx  = '0;
        end
      end
      ST_ERASE: begin
        // Buffer is left untouched across an erase
        if (flash_done) begin
          s_d.st   = ST_IDLE;
          s_d.halt = 1'b0;
        end
      end
      ST_STREAM: begin
        s_d.prog  = 1'b1;
        s_d.word  = s_q.idx;
        s_d.wdata = buf_rdata;
        s_d.idx   = s_q.idx + 1'b1;
        if (s_q.idx == {WORD_BITS{1'b1}}) begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (flash_done) begin
          s_d.st   = ST_IDLE;
          s_d.halt = 1'b0;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: ST_IDLE, wr_pend: 1'b0, addr: 8'h00, mapped: 1'b0,
               hrdata: `FSPS_RDATA_RST, hready: 1'b1, hresp: 1'b0,
               halt: 1'b0, erase: 1'b0, prog: 1'b0, page: '0,
               word: '0, idx: '0, wdata: `FSPS_ERASED_WORD};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign hreadyout   = s_q.hready;
  assign hresp       = s_q.hresp;
  assign hrdata      = s_q.hrdata;
  assign cpu_halt    = s_q.halt;
  assign flash_erase = s_q.erase;
  assign flash_prog  = s_q.prog;
  assign flash_page  = s_q.page;
  assign flash_word  = s_q.word;
  assign flash_wdata = s_q.wdata;

  // Store window and armed command
  fsps_arm_window u_arm (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .arm_load (arm_load),
    .arm_cmd  (arm_cmd),
    .fire     (program_store_instruction && !eeprom_write_busy),
    .op_done  (op_done),
    .cmd      (cur_cmd),
    .accept   (accept)
  );

  // Temporary page buffer
  fsps_page_buf #(
    .WORD_BITS (WORD_BITS)
  ) u_buf (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clr        (buf_clr),
    .we         (buf_we),
    .widx       (word_in_page_field(store_ptr)),
    .wdata      ({data_high_reg, data_low_reg}),
    .ridx       (s_q.idx),
    .rdata      (buf_rdata),
    .any_loaded (buf_any)
  );

  property p_erase_start;
    @(posedge hclk) disable iff (!hresetn)
      (accept && cur_cmd == CMD_ERASE && s_q.st == ST_IDLE) |=>
        flash_erase && cpu_halt &&
        (flash_page == page_index_field($past(store_ptr)));
  endproperty
  a_erase_start: assert property (p_erase_start)
    else $error("erase not started on accepted command");

  property p_erase_halt;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.st == ST_ERASE && !flash_done) |=> cpu_halt;
  endproperty
  a_erase_halt: assert property (p_erase_halt)
    else $error("cpu released during erase");

  property p_write_start;
    @(posedge hclk) disable iff (!hresetn)
      (accept && cur_cmd == CMD_WRITE && s_q.st == ST_IDLE) |=>
        ##1 (flash_prog && cpu_halt && flash_word == '0);
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("page write did not stream from word zero");

  property p_release;
    @(posedge hclk) disable iff (!hresetn)
      op_done |=> !cpu_halt && (s_q.st == ST_IDLE);
  endproperty
  a_release: assert property (p_release)
    else $error("halt not released after flash done");

  property p_unarmed;
    @(posedge hclk) disable iff (!hresetn)
      (program_store_instruction && cur_cmd == CMD_NONE &&
       s_q.st == ST_IDLE) |=> !flash_erase && !cpu_halt;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("store acted without arming");

  property p_ee_block;
    @(posedge hclk) disable iff (!hresetn)
      (eeprom_write_busy && cur_cmd == CMD_NONE) |=>
        (cur_cmd == CMD_NONE);
  endproperty
  a_ee_block: assert property (p_ee_block)
    else $error("armed while EEPROM busy");

endmodule

// File: fsps_readme_unused.sv
// Spare file that holds no design unit
`timescale 1ns/1ps

// File: fsps_flash_model.sv
// Flash array stand-in that answers erase and page programming with done
`timescale 1ns/1ps
module fsps_flash_model #(
  parameter int DONE_DLY = 8,
  parameter int WORDS    = 32
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Requests from the sequencer
  input  wire logic flash_erase,
  input  wire logic flash_prog,
  // Completion pulse
  output logic      flash_done
);
  int cnt;
  int nw;

  // Done comes a fixed delay after an erase or after the last word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 0;
      nw         <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= 1'b0;
      if (flash_erase) begin
        cnt <= DONE_DLY;
      end else if (flash_prog) begin
        nw <= (nw == WORDS - 1) ? 0 : nw + 1;
        if (nw == WORDS - 1) begin
          cnt <= DONE_DLY;
        end
      end else if (cnt == 1) begin
        cnt        <= 0;
        flash_done <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
module tb
  import fsps_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        pstore, eeprom_write_busy, cpu_halt;
  logic        flash_done, flash_erase, flash_prog;
  logic [15:0] sptr, flash_wdata, ex;
  logic [7:0]  dhi, dlo;
  logic [5:0]  flash_page, epg, ppg;
  logic [4:0]  flash_word;
  logic [15:0] cap [32];
  int          n_prog, n_ers, n_early, halt_bad, n_mismatch, checks_done;

  assign hready = hreadyout;

  fsps_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .program_store_instruction(pstore),
    .store_ptr(sptr), .data_high_reg(dhi), .data_low_reg(dlo),
    .eeprom_write_busy(eeprom_write_busy), .cpu_halt(cpu_halt),
    .flash_done(flash_done), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_page(flash_page),
    .flash_word(flash_word), .flash_wdata(flash_wdata));

  fsps_flash_model flash_u (.hclk(hclk), .hresetn(hresetn),
    .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_done(flash_done));

  // Clock of 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Record flash traffic seen at the array side
  always @(posedge hclk) begin
    if (flash_prog === 1'b1) begin
      cap[flash_word] <= flash_wdata;
      ppg             <= flash_page;
      n_prog          <= n_prog + 1;
      if (cpu_halt !== 1'b1) halt_bad <= halt_bad + 1;
    end
    if (flash_erase === 1'b1) begin
      n_ers <= n_ers + 1;
      epg   <= flash_page;
    end
    if (flash_done === 1'b1 && cpu_halt !== 1'b1) n_early <= n_early + 1;
  end

  task close_out;
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task hang(input logic ok);
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out;
    end
  endtask

  // Wait for hready high at a rising edge, bounded
  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 16);
    hang(hready === 1'b1);
  endtask

  // One single word transfer; read data lands in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask

  // Store strobe for one cycle with pointer and data pair
  task store(input logic [15:0] p, input logic [15:0] d);
    pstore     <= 1'b1;
    sptr       <= p;
    {dhi, dlo} <= d;
    @(posedge hclk);
    pstore     <= 1'b0;
  endtask

  // Arm a load and store into page five, pointer bit zero set
  task load(input logic [4:0] w, input logic [15:0] d);
    bus(1'b1, 32'h0, 32'h1);
    store({4'h0, 6'h05, w, 1'b1}, d);
  endtask

  task wait_lo;
    int k;
    k = 0;
    @(posedge hclk);
    while (cpu_halt !== 1'b0 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    hang(cpu_halt === 1'b0);
  endtask

  initial begin
    {hsel, hwrite, pstore, eeprom_write_busy} = 4'h0;
    {htrans, hsize, haddr, hwdata, sptr, dhi, dlo} = '0;
    {n_prog, n_ers, n_early, halt_bad, n_mismatch, checks_done} = '0;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(32'h0, 32'hffff_ffff, 32'h0);
    rdc(32'h4, 32'hffff_ffff, 32'h0);
    cmp(flash_wdata, 16'hffff);
    cmp(cpu_halt, 1'b0);
    // Unmapped place reads zero and arms nothing
    bus(1'b1, 32'h8, 32'h1);
    cmp({hresp, hreadyout}, 2'b01);
    rdc(32'h8, 32'hffff_ffff, 32'h0);
    rdc(32'h0, 32'h7, 32'h0);
    // Undefined command patterns
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'h0, (i == 0) ? 32'h07 : (i == 1) ? 32'h09 : 32'h02);
      store(16'h0142, 16'h1234);
      rdc(32'h4, 32'h4, 32'h0);
    end
    // Store one cycle past the window is refused
    bus(1'b1, 32'h0, 32'h1);
    repeat (4) @(posedge hclk);
    store(16'h0142, 16'h1234);
    rdc(32'h4, 32'h4, 32'h0);
    rdc(32'h0, 32'h1, 32'h0);
    // Store in the last cycle of the window is taken
    bus(1'b1, 32'h0, 32'h1);
    repeat (3) @(posedge hclk);
    store(16'h0142, 16'h1234);
    rdc(32'h4, 32'h4, 32'h4);
    bus(1'b1, 32'h0, 32'h11);
    rdc(32'h4, 32'h4, 32'h0);
    // EEPROM write discards loaded words and blocks commands
    load(5'h01, 16'h2222);
    eeprom_write_busy <= 1'b1;
    bus(1'b1, 32'h0, 32'h1);
    store(16'h0144, 16'h3333);
    rdc(32'h4, 32'h6, 32'h2);
    rdc(32'h0, 32'h7, 32'h0);
    eeprom_write_busy <= 1'b0;
    rdc(32'h4, 32'h4, 32'h0);
    // Reset in mid-run clears the buffer
    load(5'h03, 16'h4444);
    rdc(32'h4, 32'h4, 32'h4);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(32'h4, 32'h4, 32'h0);
    // Out of order loads, repeated word ignored
    load(5'h09, 16'ha5c3);
    load(5'h02, 16'h1e0f);
    load(5'h09, 16'h0000);
    // Erase with junk pointer bits and data
    bus(1'b1, 32'h0, 32'h3);
    store(16'hf17f, 16'hdead);
    rdc(32'h0, 32'h1, 32'h1);
    rdc(32'h4, 32'h1, 32'h1);
    wait_lo;
    cmp(n_ers, 1);
    cmp(epg, 6'h05);
    rdc(32'h4, 32'h4, 32'h4);
    rdc(32'h0, 32'h1, 32'h0);
    // Page write from the buffer, other pointer bits zero
    bus(1'b1, 32'h0, 32'h5);
    store(16'h0140, 16'h7777);
    wait_lo;
    cmp(n_prog, 32);
    cmp(ppg, 6'h05);
    for (int i = 0; i < 32; i++) begin
      ex = (i == 9) ? 16'ha5c3 : (i == 2) ? 16'h1e0f : 16'hffff;
      cmp(cap[i], ex);
    end
    cmp(halt_bad, 0);
    cmp(n_early, 0);
    rdc(32'h4, 32'h5, 32'h0);
    rdc(32'h0, 32'h1, 32'h0);
    close_out;
  end
endmodule
